// ===== hpctl_pkg.sv
// shared constants for the downstream slot hot-plug controller
package hpctl_pkg;
	localparam int NPORT_DEF = 5;
	localparam int CLK_MHZ = 100;
	localparam int ILOCK_MIN_MS = 100;
	localparam int ILOCK_MAX_MS = 150;
	// aim at the middle of the window so clock tolerance cannot push it out
	localparam int ILOCK_CYC_DEF = ((ILOCK_MIN_MS + ILOCK_MAX_MS) / 2) * 1000 * CLK_MHZ;
	localparam int ILOCK_CNT_W = 24;
	// register map: global config at A_CFG, port index n at (n + 1) * 16 + offset
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [3:0] O_CAP = 4'h0;
	localparam logic [3:0] O_CTL = 4'h4;
	localparam logic [3:0] O_STS = 4'h8;
	// slot_capabilities
	localparam int B_HPC = 0;
	localparam int B_EXP_EN = 1;
	localparam int B_RETENTION_LATCH_PRESENT = 2;
	localparam int CAP_W = 3;
	// slot_control: event enables share bit positions with slot_status flags
	localparam int B_ABP = 0;
	localparam int B_PFD = 1;
	localparam int B_LATCH_CHANGED_FLAG = 2;
	localparam int B_PDC = 3;
	localparam int B_CC = 4;
	localparam int B_HOTPLUG_IRQ_ENABLE = 5;
	localparam int B_AI_LO = 6;
	localparam int B_PI_LO = 8;
	localparam int B_PCC = 10;
	localparam int B_EIC = 11;
	localparam int CTL_W = 11;
	localparam logic [CTL_W-1:0] CTL_RST = 11'h400;
	localparam logic [1:0] IND_ON = 2'h1;
	// slot_status state bits
	localparam int B_LSS = 5;
	localparam int B_PDS = 6;
	localparam int B_EIS = 7;
	localparam int B_PGD = 8;
	localparam int FLAG_W = 5;
	// hotplug_config_control: inputs, then outputs, then modes
	localparam int I_BTN = 0;
	localparam int I_PRES = 1;
	localparam int I_PF = 2;
	localparam int I_LATCH = 3;
	localparam int I_PGOOD = 4;
	localparam int NIN = 5;
	localparam int B_INV_OUT = 5;
	localparam int Q_AI = 0;
	localparam int Q_PI = 1;
	localparam int Q_PE = 2;
	localparam int Q_IL = 3;
	localparam int NOUT = 4;
	localparam int B_TOGGLE = 9;
	localparam int B_REPLACE = 10;
	localparam int B_AUTOOFF = 11;
	localparam int CFG_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// ===== hpctl_top.sv
// downstream slot hot-plug controllers for all ports, with axi4-lite registers
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module hpctl_top import hpctl_pkg::*; #(
	parameter int NPORT = NPORT_DEF,
	parameter int ILOCK_PULSE_CYC = ILOCK_CYC_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cfg_load_active,
	input wire logic [NPORT-1:0] port_d3hot,
	input wire logic [NPORT-1:0] attention_button_in,
	input wire logic [NPORT-1:0] presence_detect_in,
	input wire logic [NPORT-1:0] power_fault_in,
	input wire logic [NPORT-1:0] retention_latch_in,
	input wire logic [NPORT-1:0] slot_power_good_in,
	output logic [NPORT-1:0] attention_indicator_out,
	output logic [NPORT-1:0] power_indicator_out,
	output logic [NPORT-1:0] slot_power_enable_out,
	output logic [NPORT-1:0] interlock_out,
	output logic expander_refresh,
	output logic [NPORT-1:0] hotplug_irq,
	output logic [NPORT-1:0] wake_req
);
	localparam logic [ILOCK_CNT_W-1:0] PULSE_LOAD = ILOCK_CNT_W'(ILOCK_PULSE_CYC);
	localparam logic [ILOCK_CNT_W-1:0] CNT_ONE = 24'h000001;

	function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic port_ok(input logic [7:0] a);
		return (a[7:4] >= 4'h1) && (32'(a[7:4]) <= NPORT);
	endfunction

	logic aw_held_ff, w_held_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [CFG_W-1:0] cfg_ff;
	logic [CAP_W-1:0] cap_ff [NPORT];
	logic [CTL_W-1:0] ctl_ff [NPORT];
	logic [FLAG_W-1:0] sts_ff [NPORT];
	logic [NIN-1:0] s1_ff [NPORT];
	logic [NIN-1:0] s2_ff [NPORT];
	logic [NIN-1:0] s3_ff [NPORT];
	logic [NIN-1:0] stable_ff [NPORT];
	logic ilock_lvl_ff [NPORT];
	logic [ILOCK_CNT_W-1:0] ilock_cnt_ff [NPORT];

	logic [31:0] w_cap [NPORT];
	logic [31:0] w_ctl [NPORT];
	logic [31:0] w_sts [NPORT];
	logic [NIN-1:0] raw [NPORT];
	logic [NIN-1:0] chg [NPORT];
	logic [NIN-1:0] lvl [NPORT];
	logic [FLAG_W-1:0] ev_set [NPORT];
	logic [FLAG_W-1:0] nxt_sts [NPORT];
	logic [NOUT-1:0] nxt_drv [NPORT];
	logic [NPORT-1:0] active, wr_cap, wr_ctl, wr_sts, eic_wr, auto_off, nxt_irq, nxt_wake;
	logic [NPORT-1:0] drv_diff;

	wire wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [3:0] wr_off = awaddr_ff[3:0];
	wire [3:0] rd_off = s_axi_araddr[3:0];
	wire wr_pok = port_ok(awaddr_ff);
	wire rd_pok = port_ok(s_axi_araddr);
	wire [2:0] wr_idx = 3'(awaddr_ff[7:4] - 4'h1);
	wire [2:0] rd_idx = 3'(s_axi_araddr[7:4] - 4'h1);
	wire [31:0] wr_clr = merge32(32'h0, wdata_ff, wstrb_ff);
	wire [31:0] wr_cfg_val = merge32(32'(cfg_ff), wdata_ff, wstrb_ff);
	wire toggle_mode = cfg_ff[B_TOGGLE];
	wire replace_mode = cfg_ff[B_REPLACE];
	wire [31:0] rd_port_word = !rd_pok ? 32'h0 :
		(rd_off == O_CAP) ? w_cap[rd_idx] :
		(rd_off == O_CTL) ? w_ctl[rd_idx] :
		(rd_off == O_STS) ? w_sts[rd_idx] : 32'h0;
	wire [31:0] rd_word = (s_axi_araddr == A_CFG) ? 32'(cfg_ff) : rd_port_word;
	wire [31:0] wr_port_old = (wr_off == O_CAP) ? w_cap[wr_idx] : w_ctl[wr_idx];
	wire [31:0] wr_port_val = merge32(wr_port_old, wdata_ff, wstrb_ff);

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		wire sel = wr_fire && wr_pok && (32'(wr_idx) == p);
		// presence only from its pin, no in-band path exists
		assign raw[p] = {slot_power_good_in[p], retention_latch_in[p], power_fault_in[p],
			presence_detect_in[p], attention_button_in[p]};
		// change counts once the last two stages agree
		assign chg[p] = (s2_ff[p] == s3_ff[p]) ? (s3_ff[p] ^ stable_ff[p]) : '0;
		assign lvl[p] = stable_ff[p] ^ cfg_ff[NIN-1:0];
		assign active[p] = cap_ff[p][B_HPC] && cap_ff[p][B_EXP_EN];
		assign wr_cap[p] = sel && (wr_off == O_CAP);
		assign wr_ctl[p] = sel && (wr_off == O_CTL);
		assign wr_sts[p] = sel && (wr_off == O_STS);
		assign eic_wr[p] = wr_ctl[p] && wdata_ff[B_EIC] && wstrb_ff[1] && active[p];
		wire [NIN-1:0] nlvl = s3_ff[p] ^ cfg_ff[NIN-1:0];
		assign ev_set[p] = !active[p] ? '0 : {
			wr_ctl[p] && !cfg_load_active,
			chg[p][I_PRES],
			chg[p][I_LATCH],
			chg[p][I_PF] && nlvl[I_PF],
			chg[p][I_BTN] && nlvl[I_BTN]};
		// set wins over a same-cycle write-one-to-clear
		assign nxt_sts[p] = (sts_ff[p] & ~(wr_sts[p] ? wr_clr[FLAG_W-1:0] : '0)) | ev_set[p];
		assign auto_off[p] = cfg_ff[B_AUTOOFF] && cap_ff[p][B_RETENTION_LATCH_PRESENT] && lvl[p][I_LATCH];
		wire [NOUT-1:0] logical = !active[p] ? '0 : {
			ilock_lvl_ff[p],
			!ctl_ff[p][B_PCC] && !auto_off[p],
			ctl_ff[p][B_PI_LO +: 2] == IND_ON,
			ctl_ff[p][B_AI_LO +: 2] == IND_ON};
		assign nxt_drv[p] = logical ^ cfg_ff[B_INV_OUT +: NOUT];
		assign drv_diff[p] = nxt_drv[p] != {interlock_out[p], slot_power_enable_out[p],
			power_indicator_out[p], attention_indicator_out[p]};
		assign nxt_irq[p] = active[p] && ctl_ff[p][B_HOTPLUG_IRQ_ENABLE]
			&& |(sts_ff[p] & ctl_ff[p][FLAG_W-1:0]);
		// command completed is left out of the wake-up term
		assign nxt_wake[p] = port_d3hot[p]
			&& |(ev_set[p][B_CC-1:0] & ctl_ff[p][B_CC-1:0]);
		assign w_cap[p] = 32'(cap_ff[p]);
		assign w_ctl[p] = 32'(ctl_ff[p]);
		assign w_sts[p] = 32'({lvl[p][I_PGOOD],
			replace_mode ? lvl[p][I_LATCH] : interlock_out[p],
			lvl[p][I_PRES],
			replace_mode ? 1'b0 : lvl[p][I_LATCH],
			sts_ff[p]});
	end

	// axi write channel: address and data taken in either order
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end else begin
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
				aw_held_ff <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_held_ff <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi read channel; unmapped offsets read as zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// registers; an eeprom loader writes through the same bus
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ff <= '0;
		end else if (wr_fire && awaddr_ff == A_CFG) begin
			cfg_ff <= wr_cfg_val[CFG_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NPORT; p++) begin
				cap_ff[p] <= '0;
				ctl_ff[p] <= CTL_RST;
				sts_ff[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				if (wr_cap[p]) cap_ff[p] <= wr_port_val[CAP_W-1:0];
				if (wr_ctl[p]) ctl_ff[p] <= wr_port_val[CTL_W-1:0];
				sts_ff[p] <= nxt_sts[p];
			end
		end
	end

	// three-stage sampling of the expander inputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NPORT; p++) begin
				s1_ff[p] <= '0;
				s2_ff[p] <= '0;
				s3_ff[p] <= '0;
				stable_ff[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				s1_ff[p] <= raw[p];
				s2_ff[p] <= s1_ff[p];
				s3_ff[p] <= s2_ff[p];
				stable_ff[p] <= stable_ff[p] ^ chg[p];
			end
		end
	end

	// interlock: pulse by core-clock count, or toggle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NPORT; p++) begin
				ilock_lvl_ff[p] <= 1'b0;
				ilock_cnt_ff[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				if (eic_wr[p] && toggle_mode) begin
					ilock_lvl_ff[p] <= !ilock_lvl_ff[p];
					ilock_cnt_ff[p] <= '0;
				end else if (eic_wr[p]) begin
					ilock_lvl_ff[p] <= 1'b1;
					ilock_cnt_ff[p] <= PULSE_LOAD;
				end else if (ilock_cnt_ff[p] != '0) begin
					ilock_cnt_ff[p] <= ilock_cnt_ff[p] - CNT_ONE;
					if (ilock_cnt_ff[p] == CNT_ONE) ilock_lvl_ff[p] <= 1'b0;
				end
			end
		end
	end

	// slot outputs; reset output lives on a gpio, not here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			attention_indicator_out <= '0;
			power_indicator_out <= '0;
			slot_power_enable_out <= '0;
			interlock_out <= '0;
			expander_refresh <= 1'b0;
			hotplug_irq <= '0;
			wake_req <= '0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				attention_indicator_out[p] <= nxt_drv[p][Q_AI];
				power_indicator_out[p] <= nxt_drv[p][Q_PI];
				slot_power_enable_out[p] <= nxt_drv[p][Q_PE];
				interlock_out[p] <= nxt_drv[p][Q_IL];
			end
			expander_refresh <= |drv_diff;
			hotplug_irq <= nxt_irq;
			wake_req <= nxt_wake;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_cc_not_by_load: assert property (wr_ctl[0] && cfg_load_active && !sts_ff[0][B_CC]
		|=> !sts_ff[0][B_CC]) else $error("load set command completed");
	a_irq_needs_hotplug_irq_enable: assert property (!ctl_ff[0][B_HOTPLUG_IRQ_ENABLE] |=> !hotplug_irq[0])
		else $error("interrupt without enable");
	a_irq_on_flag: assert property (active[0] && ctl_ff[0][B_HOTPLUG_IRQ_ENABLE] && sts_ff[0][B_ABP]
		&& ctl_ff[0][B_ABP] |=> hotplug_irq[0]) else $error("missing interrupt");
	a_wake_no_cc: assert property (ev_set[0] == (1 << B_CC) |=> !wake_req[0])
		else $error("command completed woke port");
	a_power_auto_off: assert property (active[0] && auto_off[0]
		|=> slot_power_enable_out[0] == cfg_ff[B_INV_OUT + Q_PE]) else $error("power not cut");
	a_latch_hidden: assert property (replace_mode |-> !w_sts[0][B_LSS])
		else $error("latch state shown in replace mode");
	a_eis_mirror: assert property (!replace_mode |-> w_sts[0][B_EIS] == interlock_out[0])
		else $error("interlock status mismatch");
	a_eis_replace: assert property (replace_mode |-> w_sts[0][B_EIS] == lvl[0][I_LATCH])
		else $error("interlock status not latch");
	a_ilock_toggle: assert property (eic_wr[0] && toggle_mode
		|=> ilock_lvl_ff[0] != $past(ilock_lvl_ff[0])) else $error("toggle missed");
	a_ilock_pulse: assert property (eic_wr[0] && !toggle_mode |=> ilock_lvl_ff[0]
		&& ilock_cnt_ff[0] == PULSE_LOAD) else $error("pulse not started");
	a_ilock_end: assert property (!eic_wr[0] && ilock_cnt_ff[0] == CNT_ONE
		|=> !ilock_lvl_ff[0] ##1 interlock_out[0] == cfg_ff[B_INV_OUT + Q_IL])
		else $error("pulse did not end");
	a_idle_when_off: assert property (!active[0] |=> $past(ev_set[0]) == '0 &&
		attention_indicator_out[0] == $past(cfg_ff[B_INV_OUT + Q_AI])) else $error("idle port acted");

	c_button_flag: cover property (active[0] ##1 sts_ff[0][B_ABP]);
	c_pulse_end: cover property (ilock_cnt_ff[0] == CNT_ONE ##1 !ilock_lvl_ff[0]);
	c_cc_irq: cover property (sts_ff[0][B_CC] ##1 hotplug_irq[0]);
endmodule

// ===== hpctl_slot_model.sv
// slot-side expander model: sensor pins and a held copy of the driven power enable
`timescale 1ns/10ps
module hpctl_slot_model import hpctl_pkg::*; #(
	parameter int NPORT = NPORT_DEF,
	parameter int PG_DLY = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic refresh,
	input wire logic [NPORT-1:0] pwr_en,
	input wire logic [NPORT-1:0] set_btn,
	input wire logic [NPORT-1:0] set_pres,
	input wire logic [NPORT-1:0] set_pf,
	input wire logic [NPORT-1:0] set_latch,
	output logic [NPORT-1:0] btn,
	output logic [NPORT-1:0] pres,
	output logic [NPORT-1:0] pf,
	output logic [NPORT-1:0] latch,
	output logic [NPORT-1:0] pgood,
	output logic [NPORT-1:0] pe_held
);
	logic [NPORT-1:0] held_ff;
	logic [NPORT-1:0] dly_ff [PG_DLY];
	// expander pins only move when the controller rewrites them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			held_ff <= '0;
		end else if (refresh) begin
			held_ff <= pwr_en;
		end
	end
	// slot supply ramps slowly, so power good lags the enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dly_ff <= '{default: '0};
		end else begin
			dly_ff[0] <= held_ff;
			for (int i = 1; i < PG_DLY; i++) dly_ff[i] <= dly_ff[i-1];
		end
	end
	assign pgood = dly_ff[PG_DLY-1] & held_ff;
	assign pe_held = held_ff;
	assign btn = set_btn;
	assign pres = set_pres;
	assign pf = set_pf;
	assign latch = set_latch;
endmodule

// ===== hpctl_test.sv
// self-checking bench for the slot hot-plug controller
`timescale 1ns/10ps
module hpctl_test import hpctl_pkg::*;;
	localparam int N = 5;
	localparam int PULSE = 20;
	logic clk = 0;
	logic rst_b = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid, refresh;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd_q;
	logic load = 0;
	logic [N-1:0] d3 = 0, s_btn = 0, s_pres = 0, s_pf = 0, s_latch = 0;
	logic [N-1:0] btn, pres, pf, latch, pg, ai, pi, pe, il, irq, wake, pe_held;
	int errors = 0, checked = 0, il_cnt = 0, wake_cnt = 0, il_base = 0;
	// config, slot_control, expected {interlock, power en, power ind, attn}
	logic [27:0] rows [7] = '{28'h0000405, 28'h0001006, 28'h0004000, 28'h0204001,
		28'h1e01408, 28'h0800000, 28'h0002c04};
	hpctl_top #(.NPORT(N), .ILOCK_PULSE_CYC(PULSE)) hpctl_top_inst (
		.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cfg_load_active(load), .port_d3hot(d3), .attention_button_in(btn),
		.presence_detect_in(pres), .power_fault_in(pf), .retention_latch_in(latch),
		.slot_power_good_in(pg), .attention_indicator_out(ai), .power_indicator_out(pi),
		.slot_power_enable_out(pe), .interlock_out(il), .expander_refresh(refresh),
		.hotplug_irq(irq), .wake_req(wake));
	hpctl_slot_model #(.NPORT(N)) hpctl_slot_model_inst (
		.clk(clk), .rst_b(rst_b), .refresh(refresh), .pwr_en(pe), .set_btn(s_btn),
		.set_pres(s_pres), .set_pf(s_pf), .set_latch(s_latch), .btn(btn), .pres(pres),
		.pf(pf), .latch(latch), .pgood(pg), .pe_held(pe_held));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (il[0]) il_cnt <= il_cnt + 1;
		if (wake[0]) wake_cnt <= wake_cnt + 1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid && n < 50);
		if (!bvalid) begin
			errors++;
			finish_test();
		end
		chk(bresp, RESP_OKAY);
		bready <= 0;
		// bready must not be raised again in this same time step
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 0;
		end while (!rvalid && n < 50);
		if (!rvalid) begin
			errors++;
			finish_test();
		end
		rd_q = rdata;
		rready <= 0;
		@(posedge clk);
	endtask
	initial begin
		cyc(8);
		rst_b <= 1;
		@(posedge clk);
		chk({il[0], pe[0], pi[0], ai[0]}, 0);
		rd(8'h14);
		chk(rd_q, CTL_RST);
		rd(8'hfc);
		chk(rd_q, 0);
		wr(8'h10, 32'h7);
		wr(8'h20, 32'h3);
		wr(8'h30, 32'h2);
		for (int i = 0; i < 7; i++) begin
			wr(8'h00, rows[i][27:16]);
			wr(8'h14, rows[i][15:4]);
			cyc(4);
			chk({il[0], pe[0], pi[0], ai[0]}, rows[i][3:0]);
			chk({il[1], pe[1], pi[1], ai[1]}, rows[i][24:21]);
			chk(pe_held[0], rows[i][2]);
			rd(8'h18);
			chk(rd_q[B_CC], 1);
			wr(8'h18, 32'h1f);
		end
		wr(8'h14, 32'h028);
		wr(8'h18, 32'h1f);
		s_pres <= 5'h05;
		cyc(8);
		rd(8'h18);
		chk(rd_q, 32'h148);
		chk(irq[0], 1);
		rd(8'h38);
		chk(rd_q[4:0], 0);
		wr(8'h18, 32'h08);
		cyc(2);
		chk(irq[0], 0);
		load <= 1;
		wr(8'h14, 32'h028);
		load <= 0;
		rd(8'h18);
		chk(rd_q[B_CC], 0);
		wr(8'h14, 32'h023);
		wr(8'h18, 32'h1f);
		s_btn <= 5'h01;
		s_pf <= 5'h01;
		cyc(8);
		rd(8'h18);
		chk(rd_q[4:0], 5'h03);
		chk(irq[0], 1);
		wr(8'h18, 32'h1f);
		// releasing button or fault is not an event
		s_btn <= 0;
		s_pf <= 0;
		cyc(8);
		rd(8'h18);
		chk(rd_q[4:0], 0);
		d3 <= 5'h01;
		wr(8'h14, 32'h018);
		cyc(2);
		chk(wake_cnt, 0);
		s_pres <= 5'h00;
		cyc(8);
		chk(wake_cnt, 1);
		chk(irq[0], 0);
		d3 <= 0;
		wr(8'h18, 32'h1f);
		il_base = il_cnt;
		wr(8'h14, 32'h800);
		cyc(40);
		chk(il_cnt - il_base, PULSE);
		wr(8'h00, 32'h200);
		wr(8'h14, 32'h800);
		cyc(2);
		rd(8'h18);
		chk({il[0], rd_q[B_EIS]}, 2'b11);
		wr(8'h14, 32'h800);
		cyc(2);
		chk(il[0], 0);
		wr(8'h00, 32'h400);
		s_latch <= 5'h01;
		cyc(8);
		rd(8'h18);
		chk(rd_q[7:5], 3'b100);
		wr(8'h00, 32'h800);
		cyc(4);
		chk(pe[0], 0);
		s_latch <= 0;
		cyc(8);
		chk(pe[0], 1);
		// second reset in mid-run must bring back defaults
		rst_b <= 0;
		cyc(2);
		rst_b <= 1;
		@(posedge clk);
		chk({il[0], pe[0], pi[0], ai[0], irq[0]}, 0);
		rd(8'h14);
		chk(rd_q, CTL_RST);
		finish_test();
	end
endmodule
